// file: rtl/aps_pkg.sv
// constants shared by the axis position and speed sequencer
package aps_pkg;
   // ****************************************************************
   // register word addresses
   // ****************************************************************
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_CMD = 8'h01;
   localparam logic [7:0] ADR_ADDR = 8'h02;
   localparam logic [7:0] ADR_SPEED = 8'h03;
   localparam logic [7:0] ADR_DWELL = 8'h04;
   localparam logic [7:0] ADR_DECEL = 8'h05;
   localparam logic [7:0] ADR_MCODE = 8'h06;
   localparam logic [7:0] ADR_HOME = 8'h07;
   localparam logic [7:0] ADR_STATUS = 8'h08;
   localparam logic [7:0] ADR_POS = 8'h09;
   localparam logic [7:0] ADR_MNUM = 8'h0a;
   localparam logic [7:0] ADR_ERR = 8'h0b;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int CTRL_START = 0;
   localparam int CTRL_INC = 1;
   localparam int CTRL_VEL = 2;
   localparam int CMD_HALT = 0;
   localparam int CMD_TO_POS = 1;
   localparam int CMD_TO_SPD = 2;
   localparam int CMD_AUX_CLR = 3;
   localparam int CMD_HOME = 4;
   localparam int CMD_ERR_CLR = 5;
   localparam int ST_MOVING = 0;
   localparam int ST_COMPLETE = 1;
   localparam int ST_MFLAG = 2;
   localparam int ST_ORIGIN = 3;
   localparam int ST_DIR = 4;
   localparam int ST_ERR = 5;
   localparam int ST_VEL = 6;

   // ****************************************************************
   // reset values and error codes
   // ****************************************************************
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [15:0] ERR_NO_ORIGIN = 16'd234;
   localparam logic [15:0] ERR_SW_IDLE = 16'h0f01;
   localparam logic [15:0] ERR_SW_IN_POS = 16'h0f02;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam longint CLK_PERIOD_PS = 5000;
   localparam longint TICK_TIME_PS = 1_000_000_000;
   localparam int MS_CYCLES_DEF = int'(TICK_TIME_PS / CLK_PERIOD_PS);
   localparam logic [32:0] HALF_RATE = 33'd100_000_000;
   localparam logic [2:0] DEC_SEGS_LAST = 3'h7;

   typedef enum logic [2:0] {
      APS_IDLE = 3'b000,
      APS_POS = 3'b001,
      APS_DWELL = 3'b011,
      APS_SPD = 3'b101,
      APS_DECEL = 3'b100
   } aps_state_t;
endpackage : aps_pkg

// file: rtl/aps_sequencer.sv
// single-axis position/speed sequencer with register port and pulse+direction output
//
// Summary of operation
// - absolute mode moves forward when start below target, reverse when above.
// - absolute targets refer to the home address set by the last homing.
// - start without a determined origin raises error 234 and no motion.
// - positioning-complete is asserted after a position step until the next scan boundary.
// - incremental target is current position plus the signed step address.
// - incremental positive address moves up, negative address moves down.
// - speed control outputs a steady pulse train until a stop command.
// - speed control direction follows only the sign of the step address.
// - velocity steps ignore coordinate, pattern, method, aux code and dwell.
// - speed-control stop has no dwell, no aux code, moving flag drops when deceleration ends.
// - stop deceleration time comes from the step data.
// - moving flag is asserted while the axis is in motion.
// - speed-to-position switch zeroes position and goes absolute to step address.
// - speed-to-position switch keeps the previous direction.
// - at target after switch, complete and aux flag after dwell, with code number.
// - aux flag and code number stay until the clear command clears both.
// - switch commands only while moving; while idle they raise an error, while stopped in a dwell they are ignored.
// - position-to-speed switch during speed control is ignored without error.
// - speed-to-position switch during position control errors, motion continues.
// - position-to-speed switch keeps position and runs speed control until stop.
// - stop after position-to-speed switch: no dwell, no complete flag.
// - a step begins on a rising edge of the start command.
module aps_sequencer #(
   parameter int MS_CYCLES = aps_pkg::MS_CYCLES_DEF
) (
   input wire logic mclk, // system clock, 200 MHz
   input wire logic reset, // asynchronous reset, active high
   input wire logic scan_tick, // one-cycle pulse at each controller scan boundary
   input wire logic [7:0] addr, // register word address
   input wire logic [31:0] wdata, // register write data
   input wire logic wr_en, // write strobe
   input wire logic rd_en, // read strobe
   output logic [31:0] rdata, // read data, cycle after rd_en
   output logic pulse_out, // pulse train to the drive
   output logic dir_out, // direction to the drive, high is forward
   output logic x_axis_moving_flag, // axis in motion
   output logic complete_flag // positioning complete, one scan
);
   // ****************************************************************
   // declarations
   // ****************************************************************
   aps_pkg::aps_state_t state_q;
   logic [2:0] ctrl_q;
   logic signed [31:0] addr_q, home_q;
   logic [31:0] speed_q;
   logic [15:0] dwell_q, decel_q, mcode_q;
   logic start_q, run_q, dir_q, origin_q, vel_q, inc_l;
   logic signed [31:0] pos_q, target_q, addr_l;
   logic [31:0] speed_l, cur_speed_q, spd_step_q;
   logic [15:0] dwell_l, decel_l, mcode_l, dwell_cnt_q, seg_cnt_q;
   logic [2:0] seg_idx_q;
   logic done_q, complete_q, mflag_q, err_q;
   logic [15:0] mnum_q, err_code_q;
   logic [15:0] err_set_code;
   logic err_set;
   logic [31:0] rdata_q;
   logic [32:0] acc_q, acc_sum;
   logic pulse_q, step_ev;
   logic [31:0] ms_cnt_q;
   logic ms_tick_q;
   logic start_rise;
   logic cmd_halt, cmd_to_pos, cmd_to_spd, cmd_aux_clr, cmd_home, cmd_err_clr;
   logic signed [31:0] abs_addr, inc_target;
   logic [15:0] seg_load;

   assign rdata = rdata_q;
   assign pulse_out = pulse_q;
   assign dir_out = dir_q;
   assign x_axis_moving_flag = run_q;
   assign complete_flag = complete_q;

   // ****************************************************************
   // register writes
   // ****************************************************************
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ctrl_q <= 3'h0;
         addr_q <= aps_pkg::RST_WORD;
         speed_q <= aps_pkg::RST_WORD;
         dwell_q <= 16'h0000;
         decel_q <= 16'h0000;
         mcode_q <= 16'h0000;
         home_q <= aps_pkg::RST_WORD;
      end else if (wr_en) begin
         unique case (addr)
            aps_pkg::ADR_CTRL: ctrl_q <= wdata[2:0];
            aps_pkg::ADR_ADDR: addr_q <= wdata;
            aps_pkg::ADR_SPEED: speed_q <= wdata;
            aps_pkg::ADR_DWELL: dwell_q <= wdata[15:0];
            aps_pkg::ADR_DECEL: decel_q <= wdata[15:0];
            aps_pkg::ADR_MCODE: mcode_q <= wdata[15:0];
            aps_pkg::ADR_HOME: home_q <= wdata;
            default: ;
         endcase
      end
   end

   // command bits act only in the cycle of the write
   always_comb begin
      cmd_halt = 1'b0;
      cmd_to_pos = 1'b0;
      cmd_to_spd = 1'b0;
      cmd_aux_clr = 1'b0;
      cmd_home = 1'b0;
      cmd_err_clr = 1'b0;
      if (wr_en && addr == aps_pkg::ADR_CMD) begin
         cmd_halt = wdata[aps_pkg::CMD_HALT];
         cmd_to_pos = wdata[aps_pkg::CMD_TO_POS];
         cmd_to_spd = wdata[aps_pkg::CMD_TO_SPD];
         cmd_aux_clr = wdata[aps_pkg::CMD_AUX_CLR];
         cmd_home = wdata[aps_pkg::CMD_HOME];
         cmd_err_clr = wdata[aps_pkg::CMD_ERR_CLR];
      end
   end

   // rising edge of the start level
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         start_q <= 1'b0;
      end else begin
         start_q <= ctrl_q[aps_pkg::CTRL_START];
      end
   end
   assign start_rise = ctrl_q[aps_pkg::CTRL_START] && !start_q;

   // ****************************************************************
   // millisecond tick
   // ****************************************************************
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ms_cnt_q <= 32'h0000_0000;
         ms_tick_q <= 1'b0;
      end else if (ms_cnt_q == 32'(MS_CYCLES - 1)) begin
         ms_cnt_q <= 32'h0000_0000;
         ms_tick_q <= 1'b1;
      end else begin
         ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
         ms_tick_q <= 1'b0;
      end
   end

   // ****************************************************************
   // pulse generator
   // ****************************************************************
   assign acc_sum = acc_q + {1'b0, cur_speed_q};
   assign step_ev = (state_q == aps_pkg::APS_POS || state_q == aps_pkg::APS_SPD ||
      state_q == aps_pkg::APS_DECEL) && acc_sum >= aps_pkg::HALF_RATE && !pulse_q;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         acc_q <= 33'h0_0000_0000;
         pulse_q <= 1'b0;
      end else if (state_q == aps_pkg::APS_POS || state_q == aps_pkg::APS_SPD ||
            state_q == aps_pkg::APS_DECEL) begin
         // pulse train at the current speed, lowered step by step during deceleration
         if (acc_sum >= aps_pkg::HALF_RATE) begin
            acc_q <= acc_sum - aps_pkg::HALF_RATE;
            pulse_q <= !pulse_q;
         end else begin
            acc_q <= acc_sum;
         end
      end else begin
         acc_q <= 33'h0_0000_0000;
         pulse_q <= 1'b0;
      end
   end

   // ****************************************************************
   // motion sequencer
   // ****************************************************************
   assign abs_addr = addr_l[31] ? -addr_l : addr_l;
   assign inc_target = pos_q + addr_q;
   // reload one short of decel/8 so each segment spans exactly decel/8 ticks
   assign seg_load = decel_l[15:3] == 13'h0000 ? 16'h0000 : {3'h0, decel_l[15:3] - 13'h0001};

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state_q <= aps_pkg::APS_IDLE;
         run_q <= 1'b0;
         dir_q <= 1'b0;
         origin_q <= 1'b0;
         vel_q <= 1'b0;
         inc_l <= 1'b0;
         pos_q <= aps_pkg::RST_WORD;
         target_q <= aps_pkg::RST_WORD;
         addr_l <= aps_pkg::RST_WORD;
         speed_l <= aps_pkg::RST_WORD;
         cur_speed_q <= aps_pkg::RST_WORD;
         spd_step_q <= aps_pkg::RST_WORD;
         dwell_l <= 16'h0000;
         decel_l <= 16'h0000;
         mcode_l <= 16'h0000;
         dwell_cnt_q <= 16'h0000;
         seg_cnt_q <= 16'h0000;
         seg_idx_q <= 3'h0;
         done_q <= 1'b0;
         err_set <= 1'b0;
         err_set_code <= 16'h0000;
      end else begin
         done_q <= 1'b0;
         err_set <= 1'b0;
         if (step_ev) begin
            pos_q <= dir_q ? pos_q + 32'sd1 : pos_q - 32'sd1;
         end
         unique case (state_q)
            aps_pkg::APS_IDLE: begin
               if (cmd_home) begin
                  pos_q <= home_q;
                  origin_q <= 1'b1;
               end else if (cmd_to_pos || cmd_to_spd) begin
                  err_set <= 1'b1;
                  err_set_code <= aps_pkg::ERR_SW_IDLE;
               end else if (start_rise && !origin_q) begin
                  err_set <= 1'b1;
                  err_set_code <= aps_pkg::ERR_NO_ORIGIN;
               end else if (start_rise) begin
                  // step data frozen for the whole step
                  addr_l <= addr_q;
                  speed_l <= speed_q;
                  cur_speed_q <= speed_q;
                  dwell_l <= dwell_q;
                  decel_l <= decel_q;
                  mcode_l <= mcode_q;
                  inc_l <= ctrl_q[aps_pkg::CTRL_INC];
                  vel_q <= ctrl_q[aps_pkg::CTRL_VEL];
                  run_q <= 1'b1;
                  if (ctrl_q[aps_pkg::CTRL_VEL]) begin
                     // coordinate and dwell fields play no part here
                     dir_q <= !addr_q[31];
                     state_q <= aps_pkg::APS_SPD;
                  end else if (ctrl_q[aps_pkg::CTRL_INC]) begin
                     target_q <= inc_target;
                     dir_q <= !addr_q[31];
                     state_q <= addr_q == 32'sd0 ? aps_pkg::APS_DWELL : aps_pkg::APS_POS;
                     dwell_cnt_q <= dwell_q;
                  end else begin
                     target_q <= addr_q;
                     dir_q <= pos_q < addr_q;
                     state_q <= addr_q == pos_q ? aps_pkg::APS_DWELL : aps_pkg::APS_POS;
                     dwell_cnt_q <= dwell_q;
                  end
               end
            end
            aps_pkg::APS_POS: begin
               if (cmd_halt) begin
                  state_q <= aps_pkg::APS_DECEL;
                  spd_step_q <= {3'h0, cur_speed_q[31:3]};
                  seg_cnt_q <= seg_load;
                  seg_idx_q <= 3'h0;
               end else if (cmd_to_spd) begin
                  vel_q <= 1'b1;
                  state_q <= aps_pkg::APS_SPD;
               end else if (cmd_to_pos) begin
                  err_set <= 1'b1;
                  err_set_code <= aps_pkg::ERR_SW_IN_POS;
               end
               if (!cmd_halt && !cmd_to_spd && pos_q == target_q && !pulse_q) begin
                  state_q <= aps_pkg::APS_DWELL;
                  dwell_cnt_q <= dwell_l;
               end
            end
            aps_pkg::APS_SPD: begin
               if (cmd_halt) begin
                  state_q <= aps_pkg::APS_DECEL;
                  spd_step_q <= {3'h0, cur_speed_q[31:3]};
                  seg_cnt_q <= seg_load;
                  seg_idx_q <= 3'h0;
               end else if (cmd_to_pos) begin
                  // restart the count at zero, keep heading the same way
                  pos_q <= 32'sd0;
                  target_q <= dir_q ? abs_addr : -abs_addr;
                  vel_q <= 1'b0;
                  dwell_cnt_q <= dwell_l;
                  state_q <= abs_addr == 32'sd0 ? aps_pkg::APS_DWELL : aps_pkg::APS_POS;
               end
               // a position-to-speed request here has no effect
            end
            aps_pkg::APS_DECEL: begin
               // eight equal speed steps spread over the step's decel time
               if (ms_tick_q || decel_l[15:3] == 13'h0000) begin
                  if (seg_cnt_q != 16'h0000) begin
                     seg_cnt_q <= seg_cnt_q - 16'h0001;
                  end else if (seg_idx_q == aps_pkg::DEC_SEGS_LAST) begin
                     // stop by command: no dwell, no code, no complete
                     state_q <= aps_pkg::APS_IDLE;
                     run_q <= 1'b0;
                     cur_speed_q <= speed_l;
                  end else begin
                     seg_idx_q <= seg_idx_q + 3'h1;
                     seg_cnt_q <= seg_load;
                     cur_speed_q <= cur_speed_q - spd_step_q;
                  end
               end
            end
            aps_pkg::APS_DWELL: begin
               run_q <= 1'b0;
               if (dwell_cnt_q == 16'h0000) begin
                  done_q <= 1'b1;
                  state_q <= aps_pkg::APS_IDLE;
               end else if (ms_tick_q) begin
                  dwell_cnt_q <= dwell_cnt_q - 16'h0001;
               end
            end
            default: begin
               state_q <= aps_pkg::APS_IDLE;
               run_q <= 1'b0;
            end
         endcase
      end
   end

   // ****************************************************************
   // completion, aux code and error flags
   // ****************************************************************
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         complete_q <= 1'b0;
      end else if (done_q) begin
         complete_q <= 1'b1;
      end else if (scan_tick) begin
         complete_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         mflag_q <= 1'b0;
         mnum_q <= 16'h0000;
      end else if (done_q) begin
         mflag_q <= 1'b1;
         mnum_q <= mcode_l;
      end else if (cmd_aux_clr) begin
         mflag_q <= 1'b0;
         mnum_q <= 16'h0000;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         err_q <= 1'b0;
         err_code_q <= 16'h0000;
      end else if (err_set) begin
         err_q <= 1'b1;
         err_code_q <= err_set_code;
      end else if (cmd_err_clr) begin
         err_q <= 1'b0;
         err_code_q <= 16'h0000;
      end
   end

   // ****************************************************************
   // register reads
   // ****************************************************************
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rdata_q <= aps_pkg::RST_WORD;
      end else if (rd_en) begin
         unique case (addr)
            aps_pkg::ADR_CTRL: rdata_q <= {29'h0, ctrl_q};
            aps_pkg::ADR_ADDR: rdata_q <= addr_q;
            aps_pkg::ADR_SPEED: rdata_q <= speed_q;
            aps_pkg::ADR_DWELL: rdata_q <= {16'h0000, dwell_q};
            aps_pkg::ADR_DECEL: rdata_q <= {16'h0000, decel_q};
            aps_pkg::ADR_MCODE: rdata_q <= {16'h0000, mcode_q};
            aps_pkg::ADR_HOME: rdata_q <= home_q;
            aps_pkg::ADR_STATUS: rdata_q <= {25'h0, vel_q, err_q, dir_q, origin_q,
               mflag_q, complete_q, run_q};
            aps_pkg::ADR_POS: rdata_q <= pos_q;
            aps_pkg::ADR_MNUM: rdata_q <= {16'h0000, mnum_q};
            aps_pkg::ADR_ERR: rdata_q <= {16'h0000, err_code_q};
            default: rdata_q <= aps_pkg::RST_WORD;
         endcase
      end else begin
         rdata_q <= aps_pkg::RST_WORD;
      end
   end
endmodule : aps_sequencer

// file: testbench/aps_checker.sv
// port checker for the axis sequencer
module aps_checker #(
   parameter int MS_CYCLES = 20
) (
   input wire logic mclk, // system clock
   input wire logic reset, // asynchronous reset
   input wire logic scan_tick, // scan boundary
   input wire logic [7:0] addr, // register address
   input wire logic wr_en, // write strobe
   input wire logic rd_en, // read strobe
   input wire logic [31:0] rdata, // read data
   input wire logic pulse_out, // pulse train
   input wire logic dir_out, // direction
   input wire logic x_axis_moving_flag, // moving
   input wire logic complete_flag // complete
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ctrl_wr;
   assign ctrl_wr = wr_en && (addr == aps_pkg::ADR_CTRL);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   AST_RDATA_QUIET:
      assert property (!rd_en |=> rdata == 32'h0) else $error("read data without a read");
   AST_UNMAPPED_ZERO:
      assert property (rd_en && addr > aps_pkg::ADR_ERR |=> rdata == 32'h0)
      else $error("unmapped read not zero");
   AST_COMPLETE_SCAN:
      assert property (complete_flag && scan_tick |=> !complete_flag)
      else $error("complete outlived its scan");
   AST_COMPLETE_HOLD:
      assert property (complete_flag && !scan_tick |=> complete_flag)
      else $error("complete dropped inside a scan");
   AST_COMPLETE_AFTER_STOP:
      assert property ($rose(complete_flag) |-> !x_axis_moving_flag)
      else $error("complete while moving");
   AST_PULSE_IN_MOTION:
      assert property ($rose(pulse_out) |-> x_axis_moving_flag || $past(x_axis_moving_flag))
      else $error("pulse while stopped");
   AST_DIR_KEPT:
      assert property (x_axis_moving_flag && $past(x_axis_moving_flag) |-> $stable(dir_out))
      else $error("direction changed in motion");
   AST_MOVE_NEEDS_START:
      assert property ($rose(x_axis_moving_flag) |->
         $past(ctrl_wr, 1) || $past(ctrl_wr, 2) || $past(ctrl_wr, 3))
      else $error("motion without start");
endmodule : aps_checker
bind aps_sequencer aps_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (.mclk(mclk), .reset(reset),
   .scan_tick(scan_tick), .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
   .pulse_out(pulse_out), .dir_out(dir_out), .x_axis_moving_flag(x_axis_moving_flag),
   .complete_flag(complete_flag));

// file: testbench/aps_drive_model.sv
// servo drive model that counts pulse and direction into a position
module aps_drive_model (
   input wire logic mclk, // system clock
   input wire logic reset, // asynchronous reset, active high
   input wire logic pulse_out, // pulse train from the sequencer
   input wire logic dir_out, // direction, high is forward
   output logic signed [31:0] count_q // pulses counted with sign
);
   timeunit 1ns;
   timeprecision 1ps;
   logic prev_q;
   // one count per rising pulse edge, sign from direction
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         prev_q <= 1'b0;
         count_q <= 32'sh0;
      end else begin
         prev_q <= pulse_out;
         if (pulse_out && !prev_q) begin
            count_q <= dir_out ? count_q + 32'sh1 : count_q - 32'sh1;
         end
      end
   end
endmodule : aps_drive_model

// file: testbench/tb_top.sv
// self-checking bench for the axis sequencer
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic scan_tick = 1'b0;
   logic [3:0] sc_q = 4'h0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [31:0] rdata;
   logic pulse_out, dir_out, x_axis_moving_flag, complete_flag, saw;
   logic signed [31:0] count_q, c0;
   int n_fail = 0;
   int tests_run = 0;
   aps_sequencer #(.MS_CYCLES(20)) u_dut (.mclk(mclk), .reset(reset), .scan_tick(scan_tick),
      .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
      .pulse_out(pulse_out), .dir_out(dir_out), .x_axis_moving_flag(x_axis_moving_flag),
      .complete_flag(complete_flag));
   aps_drive_model u_drv (.mclk(mclk), .reset(reset), .pulse_out(pulse_out),
      .dir_out(dir_out), .count_q(count_q));
   always #2.5 mclk = ~mclk;
   always @(posedge mclk) begin
      sc_q <= sc_q + 4'h1;
      scan_tick <= (sc_q == 4'hf);
   end
   // ****************************************************************
   // bus and check tasks
   // ****************************************************************
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", nm, exp, got);
         n_fail++;
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
      @(posedge mclk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge mclk);
      rd_en <= 1'b0;
      #1;
      chk(nm, exp, rdata);
   endtask : rdc
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   task automatic start(input logic [31:0] ctrl);
      wr(aps_pkg::ADR_CTRL, 32'h0);
      wr(aps_pkg::ADR_CTRL, ctrl);
      cyc(3);
   endtask : start
   // waits for the end of motion, then watches one more stretch for complete
   task automatic settle();
      int i;
      saw = 1'b0;
      i = 0;
      while (x_axis_moving_flag === 1'b1 && i < 8000) begin
         cyc(1);
         i++;
      end
      chk("stopped", 32'h1, {31'h0, i < 8000});
      repeat (100) begin
         cyc(1);
         if (complete_flag === 1'b1) saw = 1'b1;
      end
   endtask : settle
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize
   initial begin
      repeat (60000) @(posedge mclk);
      n_fail++;
      summarize();
   end
   initial begin
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      start(32'h1);
      rdc(aps_pkg::ADR_ERR, 32'h0000_00ea, "err");
      chk("moving", 32'h0, {31'h0, x_axis_moving_flag});
      wr(aps_pkg::ADR_CMD, 32'h20);
      $display("no origin test done");
      wr(aps_pkg::ADR_HOME, 32'h64);
      wr(aps_pkg::ADR_CMD, 32'h10);
      rdc(aps_pkg::ADR_POS, 32'h64, "home pos");
      wr(aps_pkg::ADR_ADDR, 32'h5a);
      wr(aps_pkg::ADR_SPEED, 32'h0098_9680);
      wr(aps_pkg::ADR_DWELL, 32'h1);
      wr(aps_pkg::ADR_DECEL, 32'h10);
      wr(aps_pkg::ADR_MCODE, 32'h5);
      c0 = count_q;
      start(32'h1);
      chk("dir", 32'h0, {31'h0, dir_out});
      chk("moving", 32'h1, {31'h0, x_axis_moving_flag});
      settle();
      chk("complete", 32'h1, {31'h0, saw});
      rdc(aps_pkg::ADR_POS, 32'h5a, "abs pos");
      chk("pulses", 32'hffff_fff6, count_q - c0);
      rdc(aps_pkg::ADR_MNUM, 32'h5, "mnum");
      wr(aps_pkg::ADR_CMD, 32'h08);
      rdc(aps_pkg::ADR_MNUM, 32'h0, "mnum clr");
      $display("absolute test done");
      wr(aps_pkg::ADR_ADDR, 32'hffff_fff9);
      start(32'h3);
      chk("dir", 32'h0, {31'h0, dir_out});
      settle();
      rdc(aps_pkg::ADR_POS, 32'h53, "inc pos");
      rdc(aps_pkg::ADR_MNUM, 32'h5, "inc mnum");
      wr(aps_pkg::ADR_CMD, 32'h08);
      $display("incremental test done");
      wr(aps_pkg::ADR_ADDR, 32'h5);
      wr(aps_pkg::ADR_MCODE, 32'h9);
      c0 = count_q;
      start(32'h5);
      chk("dir", 32'h1, {31'h0, dir_out});
      cyc(300);
      chk("running", 32'h1, {31'h0, count_q > c0 + 32'sh5});
      wr(aps_pkg::ADR_CMD, 32'h04);
      rdc(aps_pkg::ADR_ERR, 32'h0, "err");
      wr(aps_pkg::ADR_CMD, 32'h01);
      cyc(10);
      chk("decel", 32'h1, {31'h0, x_axis_moving_flag});
      settle();
      chk("complete", 32'h0, {31'h0, saw});
      rdc(aps_pkg::ADR_MNUM, 32'h0, "mnum");
      $display("speed test done");
      wr(aps_pkg::ADR_ADDR, 32'hf);
      wr(aps_pkg::ADR_MCODE, 32'hb);
      start(32'h5);
      cyc(50);
      wr(aps_pkg::ADR_CMD, 32'h02);
      cyc(3);
      chk("dir", 32'h1, {31'h0, dir_out});
      settle();
      chk("complete", 32'h1, {31'h0, saw});
      rdc(aps_pkg::ADR_POS, 32'hf, "sw pos");
      rdc(aps_pkg::ADR_MNUM, 32'hb, "mnum");
      wr(aps_pkg::ADR_CMD, 32'h08);
      $display("speed to position test done");
      wr(aps_pkg::ADR_ADDR, 32'hc8);
      c0 = count_q;
      start(32'h1);
      cyc(30);
      wr(aps_pkg::ADR_CMD, 32'h02);
      rdc(aps_pkg::ADR_ERR, 32'h0000_0f02, "err");
      chk("moving", 32'h1, {31'h0, x_axis_moving_flag});
      wr(aps_pkg::ADR_CMD, 32'h24);
      cyc(200);
      chk("moving", 32'h1, {31'h0, x_axis_moving_flag});
      wr(aps_pkg::ADR_CMD, 32'h01);
      settle();
      chk("complete", 32'h0, {31'h0, saw});
      rdc(aps_pkg::ADR_POS, 32'hf + (count_q - c0), "kept pos");
      $display("position to speed test done");
      wr(aps_pkg::ADR_CMD, 32'h02);
      rdc(aps_pkg::ADR_ERR, 32'h0000_0f01, "err");
      rdc(8'h20, 32'h0, "unmapped");
      $display("idle switch test done");
      summarize();
   end
endmodule : tb_top
